// >>> design/qacc_core.sv
// qacc_core: conversion control, latency pipe, coding, clamp and lfns
// assumes raw converter codes arrive on the sample clock; ahb-lite slave
//
// Overview of operation
// - a new sample is taken from the inputs on every rising clk edge
// - each sample moves one stage per edge and leaves 16 cycles later
// - every result leaves as a 16-bit word toward the serial path
// - words are coded as offset binary or two's complement
// - low-power mode uses 14-bit codes and powers down the 16-bit stage
// - resolution mode may change at any time without reset
// - first input pair feeds 16-bit path, second pair the 14-bit path
// - clamp acts only on the 14-bit inputs while clamp phase is high
// - clamp phase clock repeats one cycle high, two cycles low
// - a rising sync pulse re-aligns the clamp phase with sensor reset
// - each channel has its own noise suppression enable
// - enabled suppression moves near-dc noise to half sample rate
// - 14-bit mode only when enable bit set and select bit is one
// - format bit one gives two's complement, else offset binary
//
// Chosen here: the register addresses and the AHB-Lite slave port.
module qacc_core
   import qacc_pkg::*;
#(
   parameter int unsigned LATENCY = PIPE_LATENCY
) (
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   // ahb-lite slave
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic [31:0]                  hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   // converter side
   input  wire logic [N_CH*WORD_W-1:0]  high_res_input_pair,
   input  wire logic [N_CH*LP_W-1:0]    low_power_input_pair,
   input  wire logic                    sync_pin,
   output logic                         clamp_active,
   output logic                         front_end_power_down,
   // sample stream toward serializer
   output logic                         sample_valid,
   input  wire logic                    sample_ready,
   output logic [N_CH*WORD_W-1:0]       sample_data
);
   ////////////////////////////////////////////////////////////////////////
   // register file
   logic [15:0] mode_reg, mode_next;
   logic        fmt_reg, fmt_next;
   logic [3:0]  lfns_reg, lfns_next;
   logic        dph_wr_reg, dph_wr_next;
   logic [7:0]  dph_addr_reg, dph_addr_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic        overrun_reg, overrun_next;
   logic        lowpow;
   logic        addr_ok;

   function automatic logic [31:0] reg_read(input logic [7:0] a);
      case (a)
         OFS_MODE:   reg_read = {16'h0000, mode_reg};
         OFS_FORMAT: reg_read = {31'h0, fmt_reg};
         OFS_LFNS:   reg_read = {28'h0, lfns_reg};
         OFS_STATUS: reg_read = {29'h0, overrun_reg, clamp_active,
                                 lowpow};
         default:    reg_read = 32'h0000_0000;
      endcase
   endfunction

   assign lowpow = mode_reg[MODE_EN_BIT] && mode_reg[MODE_SEL_BIT];

   always_comb begin
      addr_ok       = hsel && hready && htrans[1];
      dph_wr_next   = addr_ok && hwrite;
      dph_addr_next = haddr[7:0];
      hrdata_next   = (addr_ok && !hwrite) ? reg_read(haddr[7:0])
                                           : 32'h0000_0000;
      mode_next     = mode_reg;
      fmt_next      = fmt_reg;
      lfns_next     = lfns_reg;
      // writes take effect at once, mode swaps live without reset
      if (dph_wr_reg) begin
         case (dph_addr_reg)
            OFS_MODE: begin
               mode_next = hwdata[15:0] & 16'h8001;
            end
            OFS_FORMAT: begin
               fmt_next = hwdata[FMT_TWOS_BIT];
            end
            OFS_LFNS: begin
               lfns_next = hwdata[3:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mode_reg     <= MODE_RST;
         fmt_reg      <= FMT_RST;
         lfns_reg     <= LFNS_RST;
         dph_wr_reg   <= 1'b0;
         dph_addr_reg <= 8'h00;
         hrdata_reg   <= 32'h0000_0000;
      end else begin
         mode_reg     <= mode_next;
         fmt_reg      <= fmt_next;
         lfns_reg     <= lfns_next;
         dph_wr_reg   <= dph_wr_next;
         dph_addr_reg <= dph_addr_next;
         hrdata_reg   <= hrdata_next;
      end
   end

   // zero wait states; every access answers okay
   assign hrdata    = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // sync pin: three flops; a level counts once the last two agree, so a
   // one-cycle glitch on the pin never moves the clamp phase
   logic [2:0]  sync_sr_reg;
   logic        sync_lvl_reg, sync_lvl_next;
   logic        sync_rise;
   qacc_clamp_t clamp_reg, clamp_next;
   logic        clamp_out_reg;

   assign sync_lvl_next = (sync_sr_reg[1] == sync_sr_reg[2]) ? sync_sr_reg[2]
                                                           : sync_lvl_reg;
   assign sync_rise     = sync_lvl_next && !sync_lvl_reg;

   always_comb begin
      case (clamp_reg)
         QACC_CLAMP_HI:  clamp_next = QACC_CLAMP_LO1;
         QACC_CLAMP_LO1: clamp_next = QACC_CLAMP_LO2;
         QACC_CLAMP_LO2: clamp_next = QACC_CLAMP_HI;
         default:        clamp_next = QACC_CLAMP_HI;
      endcase
      // realign so the high phase starts on the cycle after the edge
      if (sync_rise) begin
         clamp_next = QACC_CLAMP_HI;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sync_sr_reg   <= 3'h0;
         sync_lvl_reg  <= 1'b0;
         clamp_reg     <= QACC_CLAMP_HI;
         clamp_out_reg <= 1'b0;
      end else begin
         sync_sr_reg   <= {sync_sr_reg[1:0], sync_pin};
         sync_lvl_reg  <= sync_lvl_next;
         clamp_reg     <= clamp_next;
         // clamp gate only meaningful on the 14-bit inputs
         clamp_out_reg <= lowpow && (clamp_next == QACC_CLAMP_HI);
      end
   end

   assign clamp_active = clamp_out_reg;

   ////////////////////////////////////////////////////////////////////////
   // sample capture, suppression, coding and latency pipe
   logic [N_CH*WORD_W-1:0] cap;
   logic [N_CH*WORD_W-1:0] pipe_reg [LATENCY];
   logic [N_CH*WORD_W-1:0] pipe_next [LATENCY];
   logic [LATENCY-1:0]     pv_reg, pv_next;
   logic                   alt_reg;
   logic                   pd_reg;
   logic                   buf_in_ready;

   genvar ch;
   generate
      for (ch = 0; ch < N_CH; ch++) begin : g_ch
         logic [WORD_W-1:0] raw, shf;
         // 14-bit codes padded with two zero lsbs
         assign raw = lowpow ? {low_power_input_pair[ch*LP_W +: LP_W], 2'b00}
                             : high_res_input_pair[ch*WORD_W +: WORD_W];
         // negating on alternate cycles mixes dc up to fs/2
         assign shf = (lfns_reg[ch] && alt_reg) ? WORD_W'(~raw + 16'h0001)
                                                : raw;
         // raw codes are two's complement; flip msb for offset binary
         assign cap[ch*WORD_W +: WORD_W] =
            fmt_reg ? shf : {~shf[WORD_W-1], shf[WORD_W-2:0]};
      end
   endgenerate

   always_comb begin
      pipe_next[0] = cap;
      pv_next      = {pv_reg[LATENCY-2:0], 1'b1};
      for (int i = 1; i < LATENCY; i++) begin
         pipe_next[i] = pipe_reg[i-1];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pv_reg  <= '0;
         alt_reg <= 1'b0;
         pd_reg  <= 1'b0;
      end else begin
         pv_reg  <= pv_next;
         alt_reg <= ~alt_reg;
         pd_reg  <= lowpow;
      end
      pipe_reg <= pipe_next;
   end

   assign front_end_power_down = pd_reg;

   // the converter cannot pause, so a full buffer drops and flags
   always_comb begin
      overrun_next = overrun_reg || (pv_reg[LATENCY-1] && !buf_in_ready);
      if (dph_wr_reg && dph_addr_reg == OFS_STATUS) begin
         overrun_next = pv_reg[LATENCY-1] && !buf_in_ready;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         overrun_reg <= 1'b0;
      end else begin
         overrun_reg <= overrun_next;
      end
   end

   qacc_skid #(.W(N_CH*WORD_W)) u_buf (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (pv_reg[LATENCY-1]),
      .in_ready  (buf_in_ready),
      .in_data   (pipe_reg[LATENCY-1]),
      .out_valid (sample_valid),
      .out_ready (sample_ready),
      .out_data  (sample_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks
   latency_exact_a: assert property (@(posedge clk) disable iff (!rst_b)
      pv_reg[LATENCY-1] |-> pipe_reg[LATENCY-1] == $past(cap, LATENCY))
      else $error("pipe latency wrong");
   clamp_period_a: assert property (@(posedge clk) disable iff (!rst_b)
      (clamp_reg == QACC_CLAMP_HI && !sync_rise && !$past(sync_rise))
      ##1 !sync_rise |=> clamp_reg == QACC_CLAMP_LO2)
      else $error("clamp pattern broken");
   sync_align_a: assert property (@(posedge clk) disable iff (!rst_b)
      sync_rise |=> clamp_reg == QACC_CLAMP_HI)
      else $error("sync did not realign clamp");
   clamp_only_lp_a: assert property (@(posedge clk) disable iff (!rst_b)
      clamp_active |-> $past(lowpow))
      else $error("clamp active in 16-bit mode");
   pd_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
      $past(lowpow) == front_end_power_down)
      else $error("power down not tracking mode");
   // checked through the write path, not the decode expression itself
   mode_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      (dph_wr_reg && dph_addr_reg == OFS_MODE && !hwdata[MODE_EN_BIT])
      |=> !lowpow)
      else $error("14-bit chosen without enable");
   fmt_msb_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!fmt_reg && !lowpow && lfns_reg[0] == 1'b0) |->
      cap[WORD_W-1] == ~high_res_input_pair[WORD_W-1])
      else $error("offset binary msb wrong");
   lp_pad_a: assert property (@(posedge clk) disable iff (!rst_b)
      lowpow |-> cap[1:0] == 2'b00)
      else $error("14-bit word not padded");
   alt_toggle_a: assert property (@(posedge clk) disable iff (!rst_b)
      alt_reg |=> !alt_reg)
      else $error("suppression phase stuck");
   cov_sync: cover property (@(posedge clk) disable iff (!rst_b) sync_rise);
   cov_lp: cover property (@(posedge clk) disable iff (!rst_b)
      $rose(lowpow));
   cov_stall: cover property (@(posedge clk) disable iff (!rst_b)
      sample_valid && !sample_ready);
   cov_ovr: cover property (@(posedge clk) disable iff (!rst_b)
      $rose(overrun_reg));
endmodule

// >>> common/qacc_pkg.sv
// qacc_pkg: shared constants for the quad converter control block
// assumes a single 32-bit ahb-lite slave and one sample clock
package qacc_pkg;
   localparam int unsigned PIPE_LATENCY  = 16;
   localparam int unsigned WORD_W        = 16;
   localparam int unsigned LP_W          = 14;
   localparam int unsigned N_CH          = 4;
   localparam int unsigned CLAMP_PERIOD  = 3;
   // byte offsets of the control and status words
   localparam logic [7:0] OFS_MODE       = 8'h00;
   localparam logic [7:0] OFS_FORMAT     = 8'h04;
   localparam logic [7:0] OFS_LFNS       = 8'h08;
   localparam logic [7:0] OFS_STATUS     = 8'h0c;
   // field positions
   localparam int unsigned MODE_SEL_BIT  = 0;
   localparam int unsigned MODE_EN_BIT   = 15;
   localparam int unsigned FMT_TWOS_BIT  = 0;
   // reset values
   localparam logic [15:0] MODE_RST      = 16'h0000;
   localparam logic        FMT_RST       = 1'b0;
   localparam logic [3:0]  LFNS_RST      = 4'h0;
   typedef enum logic [2:0] {
      QACC_CLAMP_HI  = 3'b001,
      QACC_CLAMP_LO1 = 3'b010,
      QACC_CLAMP_LO2 = 3'b100
   } qacc_clamp_t;
endpackage

// >>> design/qacc_skid.sv
// qacc_skid: two-entry buffer with valid and ready on both sides
// assumes source and sink on the same clock
module qacc_skid
   import qacc_pkg::*;
#(
   parameter int unsigned W = 64
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_reg [2];
   logic [W-1:0] mem_next [2];
   logic         wp_reg, wp_next, rp_reg, rp_next;
   logic [1:0]   cnt_reg, cnt_next;
   logic         push, pop;

   always_comb begin
      push = in_valid && (cnt_reg != 2'h2);
      pop  = (cnt_reg != 2'h0) && out_ready;
      mem_next = mem_reg;
      wp_next = wp_reg;
      rp_next = rp_reg;
      if (push) begin
         mem_next[wp_reg] = in_data;
         wp_next = ~wp_reg;
      end
      if (pop) begin
         rp_next = ~rp_reg;
      end
      cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wp_reg  <= 1'b0;
         rp_reg  <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
      end
      mem_reg <= mem_next;
   end

   assign in_ready  = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data  = mem_reg[rp_reg];

   no_overflow_a: assert property (@(posedge clk) disable iff (!rst_b)
      cnt_reg != 2'h3) else $error("buffer count beyond two");
   // a stalled head must stand still, or the receiver sees a torn word
   stall_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
      else $error("buffer head moved while stalled");
endmodule

// >>> testbench/qacc_sink.sv
// qacc_sink: serializer-side receiver of the packed sample stream
// assumes the core's valid/ready handshake; stalls are commanded by the bench
module qacc_sink
   import qacc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   stall,
   input  wire logic                   valid,
   input  wire logic [N_CH*WORD_W-1:0] data,
   output logic                        ready,
   output logic [N_CH*WORD_W-1:0]      last_word,
   output int                          words
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////
   // ready moves only after an edge, so a stall never tears a word
   always @(posedge clk) begin
      ready <= rst_b & ~stall;
      if (!rst_b) begin
         words <= 0;
      end else if (valid && ready) begin
         last_word <= data;
         words <= words + 1;
      end
   end
endmodule

// >>> testbench/tb.sv
// tb: register, stream, clamp and suppression tests of the core
// assumes the core as the only ahb-lite slave and the sink as receiver
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
   mismatches++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
   end end
module tb
   import qacc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic                      clk, rst_b, hsel, hwrite, sync_pin, stall;
   logic [31:0]               haddr, hwdata, rd, hr_q;
   logic [1:0]                htrans;
   logic [2:0]                hsize;
   logic [N_CH*WORD_W-1:0]    hi_in, w0, w1;
   logic [N_CH*LP_W-1:0]      lo_in;
   wire logic [31:0]          hrdata;
   wire logic                 hreadyout, hresp, clamp_active, pdn;
   wire logic                 sample_valid, sample_ready;
   wire logic [N_CH*WORD_W-1:0] sample_data, last_word;
   int                        words, mismatches, checks_done, cycles, n;
   int                        d1, d2;
   ////////////////////////////////////////////////////////////////////////
   qacc_core #(.LATENCY(PIPE_LATENCY)) dut_u (.clk(clk), .rst_b(rst_b),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .high_res_input_pair(hi_in),
      .low_power_input_pair(lo_in), .sync_pin(sync_pin),
      .clamp_active(clamp_active), .front_end_power_down(pdn),
      .sample_valid(sample_valid), .sample_ready(sample_ready),
      .sample_data(sample_data));
   qacc_sink sink_u (.clk(clk), .rst_b(rst_b), .stall(stall),
      .valid(sample_valid), .data(sample_data), .ready(sample_ready),
      .last_word(last_word), .words(words));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // read data is captured at the closing edge, read back just after it
   always @(posedge clk) begin
      hr_q <= hrdata;
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      hsize <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      #1 rd = hr_q;
   endtask
   task automatic clamp_cnt(input int len);
      n = 0;
      repeat (len) begin
         @(posedge clk);
         #1 n += int'(clamp_active === 1'b1);
      end
   endtask
   // edges from the driving edge until lane 0 shows e, bounded
   task automatic wait_lane0(input logic [15:0] e);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (!(sample_valid === 1'b1 && sample_data[15:0] === e)
                 && n < 60);
   endtask
   // phase of the clamp pulse, seen late in a window after a sync edge
   task automatic sync_phase(output int d);
      d = -1;
      @(posedge clk);
      sync_pin <= 1'b1;
      for (int i = 1; i <= 12; i++) begin
         @(posedge clk);
         #1 if (clamp_active === 1'b1) d = i % 3;
      end
      @(posedge clk);
      sync_pin <= 1'b0;
   endtask
   task automatic note(input string s);
      $display("done: %s", s);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_b, hsel, hwrite, sync_pin, stall} = '0;
      {haddr, hwdata, htrans, hsize, lo_in, d1, d2} = '0;
      {mismatches, checks_done, cycles} = '0;
      hi_in = 64'hdef0_9abc_5678_1234;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      foreach (w0[i]) w0[i] = 1'b0;
      for (int a = 0; a <= 16; a += 4) begin
         bus(1'b0, 8'(a), 32'h0);
         `CHK(rd, 32'h0)
         `CHK({hreadyout, hresp}, 2'b10)
      end
      note("reset values");
      @(posedge clk);
      hi_in <= 64'h1234_5678_9abc_def0;
      wait_lane0(16'h5ef0);
      `CHK(n, PIPE_LATENCY + 1)
      `CHK(sample_data, 64'h9234_d678_1abc_5ef0)
      note("latency and offset binary");
      bus(1'b1, OFS_FORMAT, 32'h1);
      wait_lane0(16'hdef0);
      `CHK(sample_data, 64'h1234_5678_9abc_def0)
      note("two's complement");
      bus(1'b1, OFS_MODE, 32'h1);
      repeat (3) @(posedge clk);
      `CHK(pdn, 1'b0)
      clamp_cnt(6);
      `CHK(n, 0)
      bus(1'b1, OFS_MODE, 32'h8001);
      repeat (2) @(posedge clk);
      `CHK(pdn, 1'b1)
      clamp_cnt(9);
      `CHK(n, 3)
      @(posedge clk);
      lo_in <= 56'h0123;
      wait_lane0(16'h048c);
      `CHK(sample_data[15:0], 16'h048c)
      note("low-power mode");
      sync_phase(d1);
      repeat (3) @(posedge clk);
      sync_phase(d2);
      `CHK(d2, d1)
      `CHK(d1, 1)
      note("sync realign");
      bus(1'b1, OFS_MODE, 32'h8000);
      bus(1'b1, OFS_LFNS, 32'h1);
      repeat (40) @(posedge clk);
      `CHK(pdn, 1'b0)
      #1 w0 = sample_data;
      @(posedge clk);
      #1 w1 = sample_data;
      `CHK(16'(w0[15:0] + w1[15:0]), 16'h0)
      `CHK(w0[15:0] === 16'hdef0 || w1[15:0] === 16'hdef0, 1'b1)
      `CHK(w1[31:16], 16'h9abc)
      note("noise suppression");
      @(posedge clk);
      stall <= 1'b1;
      repeat (8) @(posedge clk);
      #1 w0 = sample_data;
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd, 32'h4)
      `CHK(sample_data, w0)
      `CHK(sample_valid, 1'b1)
      @(posedge clk);
      stall <= 1'b0;
      repeat (4) @(posedge clk);
      bus(1'b1, OFS_STATUS, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd, 32'h0)
      note("buffer stall and overrun");
      stop_test();
   end
endmodule
